//--- core/pifb_map.svh
// Register map, field positions and reset values of the peripheral flag bank.
// Assumes inclusion by bare name from package and design files.
`ifndef PIFB_MAP_SVH
`define PIFB_MAP_SVH
// ==========================================================
// Register indices (byte address = 4 * index)
`define PIFB_IDX_ENABLE_1 12'hF9D
`define PIFB_IDX_FLAGS_1 12'hF9E
`define PIFB_IDX_ENABLE_2 12'hFA0
`define PIFB_IDX_FLAGS_2 12'hFA1
`define PIFB_IDX_ENABLE_3 12'hFA3
`define PIFB_IDX_FLAGS_3 12'hFA4
`define PIFB_IDX_CONTROL 12'hFA8
`define PIFB_IDX_STATUS 12'hFA9
// ==========================================================
// Field positions
`define PIFB_BIT_PARPORT 3'h7
`define PIFB_BIT_SER_RX 3'h5
`define PIFB_BIT_SER_TX 3'h4
`define PIFB_BIT_GLOBAL_EN 3'h0
`define PIFB_BIT_PERIPH_GATE 3'h1
`define PIFB_BIT_PRIO_ON 3'h2
// ==========================================================
// Reset values and masks
`define PIFB_RESET_BYTE 8'h00
`define PIFB_SERIAL_MASK 8'h30
`define PIFB_PARPORT_MASK 8'h80
`define PIFB_FULL_MASK 8'hFF
`endif

//--- core/pifb_pkg.sv
// Types of the peripheral flag bank.
// Assumes pifb_map.svh is on the include path.
`include "pifb_map.svh"
package pifb_pkg;
  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [13:0] adr;
    logic [31:0] dat;
  } pifb_wb_req_s;
  // Per-bank group of eight event or level lines
  typedef struct packed {
    logic [7:0] bank1;
    logic [7:0] bank2;
    logic [7:0] bank3;
  } pifb_src_s;
  // Bus answer phases
  typedef enum logic [1:0] {
    PIFB_IDLE = 2'b00,
    PIFB_ACK = 2'b01
  } pifb_bus_e;
endpackage

//--- core/pifb_bank.sv
// Peripheral interrupt flag and enable bank with a classic Wishbone slave.
// Assumes one 100 MHz clock CORE_CLK and synchronous event and level inputs.
//
// What this block does
// - Flags set on events regardless of enables
// - No request without peripheral gate, no priority
// - Flag register 1 bit layout
// - Flag register 2 layout, read-write, reset clear
// - Flag register 3 layout, bits 5,4 read-only
// - Enable register 1 matches flag 1 positions
// - Enable registers 2,3 match flag positions
// - Enable one passes request, zero blocks
// - Event flags stay set until software clears
// - Parallel port transfer sets bit 7
// - Small package drops parallel port bits
// - Conversion done sets converter flag
// - Receive flag reflects unread buffer data
// - Transmit flag reflects empty transmit buffer
// - Sync port completion sets its flag
// - Capture/compare flag follows module mode
// - Timer 2 period match sets bit 1
// - Timer 1 overflow sets bit 0
// - Oscillator failure sets second bank bit 7
// - Comparator output change sets its flag
// - Peripheral gate also needs global enable
// - Priority bits act on IRQ_HIGH/IRQ_LOW only with priority on
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/10ps
`include "pifb_map.svh"

module pifb_bank #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Wishbone slave
  input wire pifb_pkg::pifb_wb_req_s WB_REQ,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Peripheral event pulses, one per flag position
  input wire pifb_pkg::pifb_src_s EVENT_IN,
  // Capture/compare module modes, bit0 unit 1, bit1 unit 2: 1 = compare
  input wire logic [1:0] CAPCMP_COMPARE_MODE,
  input wire logic [1:0] CAPCMP_CAPTURE_EV,
  input wire logic [1:0] CAPCMP_MATCH_EV,
  // Comparator outputs, bit0 comparator 1, bit1 comparator 2
  input wire logic [1:0] COMPARATOR_OUT,
  // Serial buffer levels, bit0 unit 1, bit1 unit 2
  input wire logic [1:0] SERIAL_RX_FULL,
  input wire logic [1:0] SERIAL_TX_EMPTY,
  // Priority register contents from outside, same bit layout
  input wire pifb_pkg::pifb_src_s PRIORITY_HIGH,
  // Requests to the core
  output logic PERIPH_IRQ_ANY,
  output logic IRQ_HIGH,
  output logic IRQ_LOW,
  output logic GLOBAL_IRQ_ENABLE,
  output logic PERIPH_IRQ_GATE,
  output logic PRIORITY_LEVELS_ON
);
  import pifb_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [11:0] word_index(input logic [13:0] adr);
    word_index = adr[13:2];
  endfunction

  function automatic logic [7:0] byte_lane(input logic [31:0] d, input logic [7:0] cur,
                                           input logic sel0);
    byte_lane = sel0 ? d[7:0] : cur;
  endfunction

  function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] wr,
                                           input logic wen, input logic [7:0] ev,
                                           input logic [7:0] wmask);
    logic [7:0] base;
    base = wen ? ((cur & ~wmask) | (wr & wmask)) : cur;
    flag_next = base | ev;
  endfunction

  // ==========================================================
  // Register state
  logic [7:0] peripheral_irq_flags_1;
  logic [7:0] peripheral_irq_flags_2;
  logic [7:0] peripheral_irq_flags_3;
  logic [7:0] peripheral_irq_enable_1;
  logic [7:0] peripheral_irq_enable_2;
  logic [7:0] peripheral_irq_enable_3;
  logic global_irq_enable;
  logic peripheral_irq_gate;
  logic priority_levels_on;
  logic [1:0] comparator_last;
  pifb_bus_e bus_state;

  logic [7:0] impl_mask1;
  logic [7:0] wmask1;
  logic [7:0] wmask3;
  logic [7:0] ev1;
  logic [7:0] ev2;
  logic [7:0] ev3;
  logic [1:0] capcmp_ev;
  logic [1:0] cmp_change;
  logic wr_strobe;
  logic [11:0] idx;
  logic [7:0] wbyte;
  logic [7:0] stat_byte;
  logic [7:0] ctrl_byte;
  logic [7:0] next_rdata;

  assign impl_mask1 = SMALL_PACKAGE ? ~`PIFB_PARPORT_MASK : `PIFB_FULL_MASK;
  assign wmask1 = impl_mask1 & ~`PIFB_SERIAL_MASK;
  assign wmask3 = ~`PIFB_SERIAL_MASK;
  assign idx = word_index(WB_REQ.adr);
  assign wbyte = WB_REQ.dat[7:0];
  // Writes land at the first request cycle; ack follows one edge later
  assign wr_strobe = WB_REQ.cyc && WB_REQ.stb && WB_REQ.we && WB_REQ.sel[0] &&
                     (bus_state == PIFB_IDLE);

  // ==========================================================
  // Event sources
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      capcmp_ev[i] = CAPCMP_COMPARE_MODE[i] ? CAPCMP_MATCH_EV[i] : CAPCMP_CAPTURE_EV[i];
    end
  end
  assign cmp_change = COMPARATOR_OUT ^ comparator_last;

  // Bank 1: parport, converter, rx, tx, sync1, capcmp1, tmr2, tmr1
  assign ev1 = {EVENT_IN.bank1[7:6], 2'b00, EVENT_IN.bank1[3], capcmp_ev[0],
                EVENT_IN.bank1[1:0]} & impl_mask1;
  // Bank 2: oscfail, cmp2, cmp1, usb, bcl1, hlvd, tmr3, capcmp2
  assign ev2 = {EVENT_IN.bank2[7], cmp_change[1], cmp_change[0], EVENT_IN.bank2[4:1],
                capcmp_ev[1]};
  assign ev3 = {EVENT_IN.bank3[7:6], 2'b00, EVENT_IN.bank3[3:0]};

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      comparator_last <= 2'b00;
    end else begin
      comparator_last <= COMPARATOR_OUT;
    end
  end

  // ==========================================================
  // Flag registers
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      peripheral_irq_flags_1 <= `PIFB_RESET_BYTE;
      peripheral_irq_flags_2 <= `PIFB_RESET_BYTE;
      peripheral_irq_flags_3 <= `PIFB_RESET_BYTE;
    end else begin
      peripheral_irq_flags_1 <= (flag_next(peripheral_irq_flags_1, wbyte,
          wr_strobe && idx == `PIFB_IDX_FLAGS_1, ev1, wmask1) & ~`PIFB_SERIAL_MASK) |
          ({2'b00, SERIAL_RX_FULL[0], SERIAL_TX_EMPTY[0], 4'h0});
      peripheral_irq_flags_2 <= flag_next(peripheral_irq_flags_2, wbyte,
          wr_strobe && idx == `PIFB_IDX_FLAGS_2, ev2, `PIFB_FULL_MASK);
      peripheral_irq_flags_3 <= (flag_next(peripheral_irq_flags_3, wbyte,
          wr_strobe && idx == `PIFB_IDX_FLAGS_3, ev3, wmask3) & ~`PIFB_SERIAL_MASK) |
          ({2'b00, SERIAL_RX_FULL[1], SERIAL_TX_EMPTY[1], 4'h0});
    end
  end

  // ==========================================================
  // Enable and control registers
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      peripheral_irq_enable_1 <= `PIFB_RESET_BYTE;
      peripheral_irq_enable_2 <= `PIFB_RESET_BYTE;
      peripheral_irq_enable_3 <= `PIFB_RESET_BYTE;
    end else if (wr_strobe) begin
      if (idx == `PIFB_IDX_ENABLE_1) begin
        peripheral_irq_enable_1 <= wbyte & impl_mask1;
      end else if (idx == `PIFB_IDX_ENABLE_2) begin
        peripheral_irq_enable_2 <= wbyte;
      end else if (idx == `PIFB_IDX_ENABLE_3) begin
        peripheral_irq_enable_3 <= wbyte;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      global_irq_enable <= 1'b0;
      peripheral_irq_gate <= 1'b0;
      priority_levels_on <= 1'b0;
    end else if (wr_strobe && idx == `PIFB_IDX_CONTROL) begin
      global_irq_enable <= wbyte[`PIFB_BIT_GLOBAL_EN];
      peripheral_irq_gate <= wbyte[`PIFB_BIT_PERIPH_GATE];
      priority_levels_on <= wbyte[`PIFB_BIT_PRIO_ON];
    end
  end

  // ==========================================================
  // Request combining
  logic [23:0] pending;
  logic [23:0] prio_vec;
  logic any_pending;
  logic any_high;
  logic any_low;
  assign pending = {peripheral_irq_flags_1 & peripheral_irq_enable_1,
                    peripheral_irq_flags_2 & peripheral_irq_enable_2,
                    peripheral_irq_flags_3 & peripheral_irq_enable_3};
  assign prio_vec = PRIORITY_HIGH;
  assign any_pending = |pending;
  assign any_high = |(pending & prio_vec);
  assign any_low = |(pending & ~prio_vec);
  assign PERIPH_IRQ_ANY = any_pending;
  // Without priority levels both gates must be open
  assign IRQ_HIGH = priority_levels_on ? (global_irq_enable && any_high) :
                    (global_irq_enable && peripheral_irq_gate && any_pending);
  // Low priority needs both the high and the low enable, as in the core
  assign IRQ_LOW = priority_levels_on && global_irq_enable && peripheral_irq_gate &&
                   any_low;
  assign GLOBAL_IRQ_ENABLE = global_irq_enable;
  assign PERIPH_IRQ_GATE = peripheral_irq_gate;
  assign PRIORITY_LEVELS_ON = priority_levels_on;

  // ==========================================================
  // Bus slave
  assign stat_byte = {5'h00, any_low, any_high, any_pending};
  assign ctrl_byte = {5'h00, priority_levels_on, peripheral_irq_gate, global_irq_enable};

  always_comb begin
    if (idx == `PIFB_IDX_FLAGS_1) begin
      next_rdata = peripheral_irq_flags_1 & impl_mask1;
    end else if (idx == `PIFB_IDX_FLAGS_2) begin
      next_rdata = peripheral_irq_flags_2;
    end else if (idx == `PIFB_IDX_FLAGS_3) begin
      next_rdata = peripheral_irq_flags_3;
    end else if (idx == `PIFB_IDX_ENABLE_1) begin
      next_rdata = peripheral_irq_enable_1;
    end else if (idx == `PIFB_IDX_ENABLE_2) begin
      next_rdata = peripheral_irq_enable_2;
    end else if (idx == `PIFB_IDX_ENABLE_3) begin
      next_rdata = peripheral_irq_enable_3;
    end else if (idx == `PIFB_IDX_CONTROL) begin
      next_rdata = ctrl_byte;
    end else if (idx == `PIFB_IDX_STATUS) begin
      next_rdata = stat_byte;
    end else begin
      // Unmapped reads return zero and still ack
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      bus_state <= PIFB_IDLE;
      WB_DAT_O <= 32'h00000000;
    end else begin
      case (bus_state)
        PIFB_IDLE: begin
          if (WB_REQ.cyc && WB_REQ.stb) begin
            bus_state <= PIFB_ACK;
            WB_DAT_O <= {24'h000000, next_rdata};
          end
        end
        default: begin
          bus_state <= PIFB_IDLE;
        end
      endcase
    end
  end
  assign WB_ACK_O = (bus_state == PIFB_ACK);
endmodule

//--- test/pifb_serial_model.sv
// Buffer levels of the two serial units facing the flag bank.
// Assumes bench pulses on clk; bit0 is unit 1.
`timescale 1ns/10ps
module pifb_serial_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Buffer actions
  input wire logic [1:0] rx_arrive,
  input wire logic [1:0] rx_read,
  input wire logic [1:0] tx_write,
  input wire logic [1:0] tx_done,
  // Buffer levels
  output logic [1:0] rx_full,
  output logic [1:0] tx_empty
);
  // ==========================================================
  // Levels
  // Shift time is left to the bench, so slow senders are possible
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_full <= 2'h0;
      tx_empty <= 2'h3;
    end else begin
      rx_full <= (rx_full | rx_arrive) & ~rx_read;
      tx_empty <= (tx_empty & ~tx_write) | tx_done;
    end
  end
endmodule

//--- test/pifb_bank_assertions.sv
// Port checks of the flag bank.
// Assumes a bind to pifb_bank; one clock, reset active low.
`timescale 1ns/10ps
module pifb_bank_assertions
  import pifb_pkg::*;
(
  // Clock, reset and bus
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire pifb_pkg::pifb_wb_req_s WB_REQ,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // Levels and requests
  input wire logic [1:0] SERIAL_RX_FULL,
  input wire logic [1:0] SERIAL_TX_EMPTY,
  input wire logic PERIPH_IRQ_ANY,
  input wire logic IRQ_HIGH,
  input wire logic IRQ_LOW,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic PERIPH_IRQ_GATE,
  input wire logic PRIORITY_LEVELS_ON
);
  // ==========================================================
  // Checks
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  AST_ACK_RISE: assert property (WB_REQ.cyc && WB_REQ.stb && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  AST_ACK_DROP: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  AST_UPPER_ZERO: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper data set");
  AST_GATE_BLOCK: assert property (!PRIORITY_LEVELS_ON && !PERIPH_IRQ_GATE |-> !IRQ_HIGH)
    else $error("request without gate");
  AST_GLOBAL_BLOCK: assert property (!GLOBAL_IRQ_ENABLE |-> !IRQ_HIGH && !IRQ_LOW)
    else $error("request without global");
  AST_NOPRIO_REQ: assert property (!PRIORITY_LEVELS_ON |->
    IRQ_HIGH == (GLOBAL_IRQ_ENABLE && PERIPH_IRQ_GATE && PERIPH_IRQ_ANY))
    else $error("request mismatch");
  AST_LOW_NEEDS_PRIO: assert property (!PRIORITY_LEVELS_ON || !PERIPH_IRQ_GATE |-> !IRQ_LOW)
    else $error("low request wrong");
  AST_CTRL_ON_WRITE: assert property (
    !$stable({GLOBAL_IRQ_ENABLE, PERIPH_IRQ_GATE, PRIORITY_LEVELS_ON}) |-> WB_ACK_O && WB_REQ.we)
    else $error("control moved alone");
  AST_ANY_HOLDS: assert property ($fell(PERIPH_IRQ_ANY) |-> WB_ACK_O ||
    $past(SERIAL_RX_FULL, 2) != SERIAL_RX_FULL || $past(SERIAL_TX_EMPTY, 2) != SERIAL_TX_EMPTY)
    else $error("flag cleared alone");
endmodule

//--- test/test_pifb_bank.sv
// Self-checking bench of the flag bank.
// Assumes package, map header, serial model and checker compiled first.
`timescale 1ns/10ps
`include "pifb_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  errors++; $display("[FAIL] %0t got %0h want %0h", $time, g, e); end end
module test_pifb_bank;
  import pifb_pkg::*;
  logic CORE_CLK, RST_N, WB_ACK_O, PERIPH_IRQ_ANY, IRQ_HIGH, IRQ_LOW;
  logic GLOBAL_IRQ_ENABLE, PERIPH_IRQ_GATE, PRIORITY_LEVELS_ON;
  logic [31:0] WB_DAT_O;
  pifb_wb_req_s WB_REQ;
  pifb_src_s EVENT_IN, PRIORITY_HIGH;
  logic [1:0] CAPCMP_COMPARE_MODE, CAPCMP_CAPTURE_EV, CAPCMP_MATCH_EV, COMPARATOR_OUT;
  logic [1:0] SERIAL_RX_FULL, SERIAL_TX_EMPTY, rx_arrive, rx_read, tx_write, tx_done;
  int errors = 0;
  int check_count = 0;
  logic [8:0] exp_q[$];
  logic [8:0] got_e;
  logic [7:0] en [3];
  logic [11:0] ens [3] = '{`PIFB_IDX_ENABLE_1, `PIFB_IDX_ENABLE_2, `PIFB_IDX_ENABLE_3};
  logic [11:0] f1 = `PIFB_IDX_FLAGS_1;
  logic [11:0] f2 = `PIFB_IDX_FLAGS_2;
  logic [11:0] f3 = `PIFB_IDX_FLAGS_3;
  // {prio, gate, global, high-priority sources, want high, want low}
  logic [5:0] tbl [7] = '{6'h00, 6'h08, 6'h10, 6'h1A, 6'h39, 6'h3E, 6'h28};
  pifb_bank pifb_bank_i (.*);
  pifb_serial_model pifb_serial_model_i (.clk(CORE_CLK), .rst_n(RST_N),
    .rx_arrive(rx_arrive), .rx_read(rx_read), .tx_write(tx_write), .tx_done(tx_done),
    .rx_full(SERIAL_RX_FULL), .tx_empty(SERIAL_TX_EMPTY));
  // ==========================================================
  // Clock, bus tasks and read monitor
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d,
      input logic [8:0] e);
    int n = 0;
    exp_q.push_back(e);
    WB_REQ <= '{1'b1, 1'b1, w, 4'h1, {a, 2'h0}, {24'h0, d}};
    do @(posedge CORE_CLK); while (WB_ACK_O !== 1'b1 && ++n < 50);
    if (n >= 50) errors++;
    WB_REQ <= '0;
    @(posedge CORE_CLK);
  endtask
  task automatic r(input logic [11:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00, {1'b1, e});
  endtask
  task automatic w(input logic [11:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 9'h000);
  endtask
  task automatic pulse(input logic [23:0] v);
    EVENT_IN <= v;
    @(posedge CORE_CLK);
    EVENT_IN <= '0;
  endtask
  always @(posedge CORE_CLK) begin
    if (WB_ACK_O === 1'b1 && exp_q.size() > 0) begin
      got_e = exp_q.pop_front();
      if (got_e[8]) `CHK(WB_DAT_O, {24'h0, got_e[7:0]})
    end
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge CORE_CLK);
    errors++;
    wrap_up;
  end
  // ==========================================================
  // Scenarios
  initial begin
    {RST_N, WB_REQ, EVENT_IN, PRIORITY_HIGH, CAPCMP_COMPARE_MODE} = '0;
    {CAPCMP_CAPTURE_EV, CAPCMP_MATCH_EV, COMPARATOR_OUT} = '0;
    {rx_arrive, rx_read, tx_write, tx_done} = '0;
    void'($urandom(36));
    repeat (20) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    foreach (ens[i]) r(ens[i], 8'h00);
    r(f1, 8'h10); r(f2, 8'h00); r(f3, 8'h10); r(12'hF00, 8'h00);
    pulse(24'hFFFFFF);
    r(f1, 8'hDB); r(f2, 8'h9E); r(f3, 8'hDF);
    `CHK(PERIPH_IRQ_ANY, 1'b0)
    foreach (ens[i]) begin
      en[i] = 8'($urandom);
      w(ens[i], en[i]);
      r(ens[i], en[i]);
    end
    `CHK(PERIPH_IRQ_ANY, |({en[0], en[1], en[2]} & 24'hDB9EDF))
    w(f1, 8'h00); w(f2, 8'h00); w(f3, 8'h00);
    CAPCMP_COMPARE_MODE <= 2'h1;
    CAPCMP_CAPTURE_EV <= 2'h3;
    @(posedge CORE_CLK);
    CAPCMP_CAPTURE_EV <= 2'h0;
    r(f2, 8'h01); r(f1, 8'h10);
    CAPCMP_MATCH_EV <= 2'h3;
    COMPARATOR_OUT <= 2'h1;
    @(posedge CORE_CLK);
    CAPCMP_MATCH_EV <= 2'h0;
    r(f1, 8'h14); r(f2, 8'h21);
    fork
      w(f2, 8'h00);
      pulse(24'h008000);
    join
    r(f2, 8'h80);
    rx_arrive <= 2'h2;
    tx_write <= 2'h3;
    @(posedge CORE_CLK);
    {rx_arrive, tx_write} <= '0;
    repeat (2) @(posedge CORE_CLK);
    w(f3, 8'h3F);
    r(f3, 8'h2F); r(f1, 8'h04);
    rx_read <= 2'h2;
    tx_done <= 2'h1;
    @(posedge CORE_CLK);
    {rx_read, tx_done} <= '0;
    repeat (2) @(posedge CORE_CLK);
    r(f3, 8'h0F); r(f1, 8'h14);
    w(ens[0], 8'h04); w(ens[1], 8'h00); w(ens[2], 8'h00);
    foreach (tbl[i]) begin
      PRIORITY_HIGH <= {24{tbl[i][2]}};
      w(`PIFB_IDX_CONTROL, {5'h00, tbl[i][5:3]});
      `CHK({PRIORITY_LEVELS_ON, PERIPH_IRQ_GATE, GLOBAL_IRQ_ENABLE}, tbl[i][5:3])
      `CHK({IRQ_HIGH, IRQ_LOW}, tbl[i][1:0])
      r(`PIFB_IDX_STATUS, {5'h00, !tbl[i][2], tbl[i][2], 1'b1});
    end
    w(f1, 8'h00);
    `CHK(PERIPH_IRQ_ANY, 1'b0)
    wrap_up;
  end
endmodule
bind pifb_bank pifb_bank_assertions pifb_bank_assertions_i (.*);
